// *** pcp_pkg.sv ***
// Behaviour
// R01: Record each active/idle period into buffer
// R02: Full buffer drops oldest before storing
// R03: Idle level is reference at each start
// R04: Pause or capture error halts, flag set
// R05: Nonzero trigger width pulses line first
// R06: Partner drives line open drain only
// R07: Clear empties; take returns and removes oldest
// R08: Count and indexed entry readable, non-destructive
// R09: Train gates carrier on/off, on first
// R10: Done after last duration; carrier left off
// R11: Sixteen-bit duty sets high fraction
// R12: Frequency in hertz, default 500, fixed; code follows freq_i while var_freq_i was set at setup
// R13: Reset or release stops output
// R14: Duration counts microseconds, saturates at max
package pcp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] US_LAST = 6'(US_CYC - 1);
  // ****************************************
  // Values
  // ****************************************
  localparam logic [15:0] DUR_MAX = 16'hFFFF;
  localparam logic [15:0] DUTY_FULL = 16'hFFFF;
  localparam logic [15:0] DUTY_NONE = 16'h0000;
  localparam logic [31:0] FREQ_DEF = 32'h000001F4;
  localparam logic TRIG_LEVEL = 1'b0;
  typedef enum logic [1:0] {
    CAP_HALT = 2'b00,
    CAP_TRIG = 2'b01,
    CAP_RUN = 2'b11
  } pcp_cap_st_t;
endpackage

// *** pcp_top.sv ***
`timescale 1ns/100ps
module pcp_top #(
  parameter int CAP_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Pulsed line
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o,
  // Capture control
  input wire logic idle_level_i,
  input wire logic pause_i,
  input wire logic resume_i,
  input wire logic [15:0] trig_us_i,
  input wire logic clear_i,
  input wire logic take_i,
  input wire logic [15:0] idx_i,
  // Capture status
  output logic halted_o,
  output logic [15:0] count_o,
  output logic [15:0] idx_data_o,
  output logic [15:0] take_data_o,
  output logic take_valid_o,
  // Pulse train stream
  input wire logic train_en_i,
  input wire logic dur_valid_i,
  input wire logic [15:0] dur_data_i,
  input wire logic dur_last_i,
  output logic dur_ready_o,
  output logic done_o,
  // PWM control
  input wire logic setup_i,
  input wire logic release_i,
  input wire logic var_freq_i,
  input wire logic [15:0] duty_i,
  input wire logic [31:0] freq_i,
  output logic pwm_o
);
  localparam int AW = (CAP_DEPTH > 1) ? $clog2(CAP_DEPTH) : 1;
  initial begin
    if (CAP_DEPTH < 2 || (1 << AW) != CAP_DEPTH || CAP_DEPTH > 32768) begin
      $error("CAP_DEPTH must be a power of two from 2");
    end
  end
  // ****************************************
  // Microsecond tick
  // ****************************************
  logic [5:0] presc_q;
  logic tick;
  assign tick = (presc_q == pcp_pkg::US_LAST);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc_q <= 6'h00;
    end else begin
      presc_q <= tick ? 6'h00 : presc_q + 6'h01;
    end
  end
  // ****************************************
  // Capture sequencer
  // ****************************************
  pcp_pkg::pcp_cap_st_t st_q, st_d;
  logic [15:0] trig_rem_q, dur_q;
  logic cur_lvl_q, first_q, cap_edge, rec, err;
  assign cap_edge = (st_q == pcp_pkg::CAP_RUN) && (line_i != cur_lvl_q);
  // R01 period recorded
  assign rec = cap_edge && !first_q && (dur_q != 16'h0000);
  // R04 too fast error
  assign err = cap_edge && !first_q && (dur_q == 16'h0000);
  always_comb begin
    st_d = st_q;
    case (st_q)
      pcp_pkg::CAP_HALT: begin
        // R05 optional trigger
        if (resume_i) begin
          st_d = (trig_us_i != 16'h0000) ? pcp_pkg::CAP_TRIG : pcp_pkg::CAP_RUN;
        end
      end
      pcp_pkg::CAP_TRIG: begin
        if (tick && trig_rem_q == 16'h0001) begin
          st_d = pcp_pkg::CAP_RUN;
        end
      end
      pcp_pkg::CAP_RUN: begin
        if (err) begin
          st_d = pcp_pkg::CAP_HALT;
        end
      end
      default: st_d = pcp_pkg::CAP_HALT;
    endcase
    // R04 pause halts
    if (pause_i) begin
      st_d = pcp_pkg::CAP_HALT;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= pcp_pkg::CAP_HALT;
      trig_rem_q <= 16'h0000;
      halted_o <= 1'b1;
      line_oe_o <= 1'b0;
    end else begin
      st_q <= st_d;
      halted_o <= (st_d == pcp_pkg::CAP_HALT);
      // R06 drives low only
      line_oe_o <= (st_d == pcp_pkg::CAP_TRIG);
      if (st_q == pcp_pkg::CAP_HALT) begin
        trig_rem_q <= trig_us_i;
      end else if (tick && trig_rem_q != 16'h0000) begin
        trig_rem_q <= trig_rem_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_o <= pcp_pkg::TRIG_LEVEL;
    end else begin
      line_o <= pcp_pkg::TRIG_LEVEL;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_lvl_q <= 1'b0;
      first_q <= 1'b1;
      dur_q <= 16'h0000;
    end else if (st_d == pcp_pkg::CAP_RUN && st_q != pcp_pkg::CAP_RUN) begin
      // R03 idle reference
      cur_lvl_q <= idle_level_i;
      first_q <= 1'b1;
      dur_q <= 16'h0000;
    end else if (cap_edge) begin
      cur_lvl_q <= line_i;
      first_q <= 1'b0;
      dur_q <= 16'h0000;
    end else if (tick && dur_q != pcp_pkg::DUR_MAX) begin
      // R14 saturating count
      dur_q <= dur_q + 16'h0001;
    end
  end
  // ****************************************
  // Capture buffer
  // ****************************************
  logic [15:0] mem_q [CAP_DEPTH];
  logic [AW-1:0] rd_q, rd_t;
  logic [AW:0] cnt_q, cnt_t;
  logic take_ok;
  assign take_ok = take_i && !clear_i && (cnt_q != '0);
  assign rd_t = rd_q + AW'(take_ok);
  assign cnt_t = cnt_q - (AW+1)'(take_ok);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clear_i) begin
      // R07 clear
      rd_q <= '0;
      cnt_q <= '0;
    end else if (rec && cnt_t == (AW+1)'(CAP_DEPTH)) begin
      // R02 drop oldest
      rd_q <= rd_t + AW'(1);
      cnt_q <= cnt_t;
    end else begin
      rd_q <= rd_t;
      cnt_q <= cnt_t + (AW+1)'(rec);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rec && !clear_i) begin
      mem_q[rd_t + cnt_t[AW-1:0]] <= dur_q;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      take_data_o <= 16'h0000;
      take_valid_o <= 1'b0;
      idx_data_o <= 16'h0000;
      count_o <= 16'h0000;
    end else begin
      // R07 take oldest
      take_valid_o <= take_ok;
      if (take_ok) begin
        take_data_o <= mem_q[rd_q];
      end
      // R08 non-destructive read
      idx_data_o <= (idx_i < 16'(cnt_q)) ? mem_q[rd_q + idx_i[AW-1:0]] : 16'h0000;
      count_o <= 16'(cnt_q);
    end
  end
  // ****************************************
  // Train buffer
  // ****************************************
  logic [16:0] fb_q [2];
  logic fwp_q, frp_q, f_pop, f_push;
  logic [1:0] fcnt_q, fcnt_d;
  assign f_push = dur_valid_i && dur_ready_o;
  assign fcnt_d = fcnt_q + 2'(f_push) - 2'(f_pop);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fwp_q <= 1'b0;
      frp_q <= 1'b0;
      fcnt_q <= 2'h0;
      dur_ready_o <= 1'b1;
    end else begin
      fwp_q <= fwp_q ^ f_push;
      frp_q <= frp_q ^ f_pop;
      fcnt_q <= fcnt_d;
      dur_ready_o <= (fcnt_d != 2'h2);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (f_push) begin
      fb_q[fwp_q] <= {dur_last_i, dur_data_i};
    end
  end
  // ****************************************
  // Train sequencer
  // ****************************************
  logic busy_q, last_q, gate_q;
  logic [15:0] rem_q;
  assign f_pop = (fcnt_q != 2'h0) && (!busy_q || (rem_q == 16'h0000 && !last_q));
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      last_q <= 1'b0;
      gate_q <= 1'b0;
      rem_q <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (f_pop) begin
        // R09 alternate on first
        busy_q <= 1'b1;
        gate_q <= busy_q ? !gate_q : 1'b1;
        rem_q <= fb_q[frp_q][15:0];
        last_q <= fb_q[frp_q][16];
      end else if (busy_q && rem_q == 16'h0000 && last_q) begin
        // R10 finish gated off
        busy_q <= 1'b0;
        gate_q <= 1'b0;
        done_o <= 1'b1;
      end else if (tick && rem_q != 16'h0000) begin
        rem_q <= rem_q - 16'h0001;
      end
    end
  end
  // ****************************************
  // PWM
  // ****************************************
  logic run_q, var_q, high;
  logic [15:0] duty_q;
  logic [31:0] freq_q, acc_q;
  logic [32:0] sum;
  assign sum = {1'b0, acc_q} + {1'b0, freq_q};
  // R11 duty compare
  assign high = (duty_q == pcp_pkg::DUTY_FULL) ||
    ({acc_q, 16'h0000} < 48'(duty_q) * 48'(pcp_pkg::CLK_HZ));
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= 1'b0;
      var_q <= 1'b0;
      duty_q <= pcp_pkg::DUTY_NONE;
      freq_q <= pcp_pkg::FREQ_DEF;
      acc_q <= 32'h00000000;
      pwm_o <= 1'b0;
    end else begin
      duty_q <= duty_i;
      if (release_i) begin
        // R13 release stops
        run_q <= 1'b0;
        acc_q <= 32'h00000000;
      end else if (setup_i) begin
        run_q <= 1'b1;
        var_q <= var_freq_i;
        freq_q <= freq_i;
        acc_q <= 32'h00000000;
      end else begin
        // R12 fixed unless variable
        if (var_q) begin
          freq_q <= freq_i;
        end
        if (run_q) begin
          acc_q <= (sum >= 33'(pcp_pkg::CLK_HZ)) ? 32'(sum - 33'(pcp_pkg::CLK_HZ)) : sum[31:0];
        end
      end
      pwm_o <= run_q && high && (!train_en_i || gate_q);
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  property p_rec_grow;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      rec && !clear_i && !take_i && cnt_q < (AW+1)'(CAP_DEPTH) |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_rec_grow: assert property (p_rec_grow) else $error("record did not grow count"); // R01
  property p_full_drop;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      rec && !clear_i && !take_i && cnt_q == (AW+1)'(CAP_DEPTH) |=> count_o == 16'(CAP_DEPTH)
        ##0 rd_q == $past(rd_q) + 1'b1;
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full buffer did not drop"); // R02
  property p_ref;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      st_q != pcp_pkg::CAP_RUN ##1 st_q == pcp_pkg::CAP_RUN |-> first_q && cur_lvl_q == $past(idle_level_i);
  endproperty
  a_ref: assert property (p_ref) else $error("run entry lost idle reference"); // R03
  property p_pause;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      pause_i || err |=> halted_o && !line_oe_o;
  endproperty
  a_pause: assert property (p_pause) else $error("pause or error did not halt"); // R04
  property p_trig;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      halted_o && resume_i && !pause_i && trig_us_i != 16'h0000 |=> line_oe_o [*8];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse not driven"); // R05
  property p_clear;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      clear_i |=> ##1 count_o == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left entries"); // R07
  property p_take;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      take_i && !clear_i && !rec && cnt_q != '0 |=> take_valid_o && take_data_o == $past(mem_q[rd_q])
        ##1 count_o == 16'($past(cnt_q, 2)) - 16'h0001;
  endproperty
  a_take: assert property (p_take) else $error("take failed"); // R07
  property p_done;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      done_o |-> !gate_q && !busy_q;
  endproperty
  a_done: assert property (p_done) else $error("carrier not off at end"); // R10
  property p_duty;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      run_q && !release_i && !setup_i && duty_q == pcp_pkg::DUTY_NONE |=> !pwm_o;
  endproperty
  a_duty: assert property (p_duty) else $error("zero duty drove high"); // R11
  property p_fixed;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      !var_q && !setup_i |=> $stable(freq_q);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed frequency changed"); // R12
  property p_release;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      release_i ##1 !setup_i |=> !pwm_o;
  endproperty
  a_release: assert property (p_release) else $error("release left output"); // R13
  property p_sat;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      st_q == pcp_pkg::CAP_RUN && st_d == pcp_pkg::CAP_RUN && !cap_edge && dur_q == pcp_pkg::DUR_MAX
        |=> dur_q == pcp_pkg::DUR_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("duration wrapped"); // R14
endmodule // pcp_top

// *** pcp_ir_model.sv ***
`timescale 1ns/100ps
module pcp_ir_model (
  // Clock
  input wire logic clk_sys_i,
  // Device drive of the line
  input wire logic dev_lvl_i,
  input wire logic dev_oe_i,
  // Resolved line level
  output logic line_o
);
  logic low_q = 1'b0;
  // open drain only
  // Pull-up wins unless a party pulls low
  assign line_o = ~(low_q | (dev_oe_i & ~dev_lvl_i));
  // Hold line low or released for n cycles
  task automatic hold(input logic low, input int n);
    low_q = low;
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
endmodule // pcp_ir_model

// *** test_pulse_capture_and_pwm_out.sv ***
`timescale 1ns/100ps
module test_pulse_capture_and_pwm_out;
  localparam int US = pcp_pkg::US_CYC;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, idle_level_i = 1'b1;
  logic pause_i = 1'b0, resume_i = 1'b0, clear_i = 1'b0, take_i = 1'b0;
  logic train_en_i = 1'b0, dur_valid_i = 1'b0, dur_last_i = 1'b0;
  logic setup_i = 1'b0, release_i = 1'b0, var_freq_i = 1'b0;
  logic [15:0] trig_us_i = 16'h0000, idx_i = 16'h0000;
  logic [15:0] dur_data_i = 16'h0000, duty_i = 16'h0000;
  logic [31:0] freq_i = 32'h000186A0;
  logic line_o, line_oe_o, w_line, halted_o, take_valid_o, dur_ready_o, done_o, pwm_o;
  logic [15:0] count_o, idx_data_o, take_data_o;
  int n_fail = 0, n_tests = 0;
  pcp_top #(.CAP_DEPTH(2)) i_pcp_top (.clk_sys_i, .rst_b_i, .line_i(w_line), .line_o,
    .line_oe_o, .idle_level_i, .pause_i, .resume_i, .trig_us_i, .clear_i, .take_i, .idx_i,
    .halted_o, .count_o, .idx_data_o, .take_data_o, .take_valid_o, .train_en_i,
    .dur_valid_i, .dur_data_i, .dur_last_i, .dur_ready_o, .done_o, .setup_i, .release_i,
    .var_freq_i, .duty_i, .freq_i, .pwm_o);
  pcp_ir_model i_pcp_ir_model (.clk_sys_i, .dev_lvl_i(line_o), .dev_oe_i(line_oe_o),
    .line_o(w_line));
  always #12.5 clk_sys_i = ~clk_sys_i;
  // ****************
  // Helpers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic rd(input logic [15:0] i, input int lo, input int hi, input string m);
    idx_i = i;
    tick(2);
    chk(idx_data_o >= lo && idx_data_o <= hi, m);
  endtask
  task automatic push(input logic [15:0] d, input logic l);
    dur_valid_i = 1'b1;
    dur_data_i = d;
    dur_last_i = l;
    while (dur_ready_o !== 1'b1) tick(1);
    tick(1);
  endtask
  task automatic meas(input int n, output int hi, output int ed);
    logic p;
    hi = 0;
    ed = 0;
    p = pwm_o;
    repeat (n) begin
      tick(1);
      chk(pwm_o === 1'b0 || pwm_o === 1'b1, "pwm unknown");
      hi += pwm_o;
      ed += int'(pwm_o & ~p);
      p = pwm_o;
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk(halted_o === 1'b1 && count_o === 16'h0000, "reset cap");
    chk(dur_ready_o === 1'b1 && pwm_o === 1'b0 && line_oe_o === 1'b0, "reset out");
  endtask
  task automatic t_capture();
    pulse(resume_i);
    i_pcp_ir_model.hold(1'b1, 5 * US);
    i_pcp_ir_model.hold(1'b0, 7 * US);
    chk(count_o === 16'h0001, "first entry");
    rd(16'h0000, 4, 6, "first low");
    i_pcp_ir_model.hold(1'b1, 3 * US);
    rd(16'h0001, 6, 8, "idle len");
    i_pcp_ir_model.hold(1'b0, 2 * US);
    chk(count_o === 16'h0002, "depth");
    rd(16'h0000, 6, 8, "oldest dropped");
    rd(16'h0001, 2, 4, "newest");
    pulse(pause_i);
    tick(2);
    chk(halted_o === 1'b1, "pause");
    i_pcp_ir_model.hold(1'b1, US);
    i_pcp_ir_model.hold(1'b0, US);
    chk(count_o === 16'h0002, "paused rec");
    pulse(take_i);
    chk(take_valid_o === 1'b1 && take_data_o >= 6 && take_data_o <= 8, "take");
    tick(2);
    chk(count_o === 16'h0001, "take cnt");
    rd(16'h0000, 2, 4, "after take");
    pulse(clear_i);
    tick(2);
    chk(count_o === 16'h0000, "clear");
    rd(16'h0000, 0, 0, "empty idx");
  endtask
  task automatic t_trigger();
    int n;
    n = 0;
    trig_us_i = 16'h0004;
    pulse(resume_i);
    repeat (250) begin
      n += int'(line_oe_o & ~w_line);
      tick(1);
    end
    chk(n >= 115 && n <= 165, "trig width");
    chk(halted_o === 1'b0 && line_oe_o === 1'b0, "trig run");
    trig_us_i = 16'h0000;
    pulse(pause_i);
    tick(2);
    pulse(resume_i);
    tick(4);
    chk(halted_o === 1'b0 && line_oe_o === 1'b0, "direct run");
    i_pcp_ir_model.hold(1'b1, 1);
    i_pcp_ir_model.hold(1'b0, 6);
    chk(halted_o === 1'b1, "fast edge");
  endtask
  task automatic t_train();
    int hi, n;
    hi = 0;
    n = 0;
    duty_i = 16'hFFFF;
    train_en_i = 1'b1;
    pulse(setup_i);
    tick(3);
    chk(pwm_o === 1'b0, "gate idle");
    push(16'h0003, 1'b0);
    push(16'h0000, 1'b0);
    push(16'h0002, 1'b1);
    dur_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 400) begin
      hi += pwm_o;
      n++;
      tick(1);
    end
    chk(done_o === 1'b1 && hi >= 150 && hi <= 210, "train");
    tick(2);
    chk(pwm_o === 1'b0 && done_o === 1'b0, "gate off");
    train_en_i = 1'b0;
  endtask
  task automatic t_pwm();
    int hi, ed;
    duty_i = 16'h7FFF;
    pulse(setup_i);
    tick(4);
    meas(4000, hi, ed);
    chk(hi >= 1950 && hi <= 2050 && ed >= 9 && ed <= 11, "half duty");
    freq_i = 32'h00030D40;
    meas(4000, hi, ed);
    chk(ed >= 9 && ed <= 11, "fixed freq");
    duty_i = 16'h0000;
    tick(3);
    meas(800, hi, ed);
    chk(hi == 0, "duty none");
    duty_i = 16'hFFFF;
    tick(3);
    meas(800, hi, ed);
    chk(hi == 800, "duty full");
    duty_i = 16'h7FFF;
    var_freq_i = 1'b1;
    freq_i = 32'h000186A0;
    pulse(setup_i);
    freq_i = 32'h00030D40;
    tick(3);
    meas(4000, hi, ed);
    chk(ed >= 19 && ed <= 21, "var freq");
    pulse(release_i);
    tick(2);
    meas(800, hi, ed);
    chk(hi == 0, "release");
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_fail++;
    complete_run();
  end
  initial begin
    tick(7);
    t_reset();
    tick(1);
    rst_b_i = 1'b1;
    tick(2);
    t_capture();
    t_trigger();
    t_train();
    t_pwm();
    complete_run();
  end
endmodule // test_pulse_capture_and_pwm_out
